// ### hw/dcf_fifo.sv
// Dual-port 9-bit FIFO with pin ports, flags and an AXI4-Lite register slave
// Function
// - Reset returns both pointers to first location
// - Reset forces full flags high, empty low
// - Reset clears output register, loads default offsets
// - Nine-bit input bus and output bus
// - Flag mode: write when enable one low
// - Words stored in order, independent of reads
// - Enable one high holds input register
// - Full drives flag low, writes ignored
// - Read on full buffer releases full flag
// - Full flags change on aclk edges, set by writes, released by reads
// - Empty flags change on aclk edges, set by reads, released by writes
// - Asynchronous pins sampled through two sync stages on aclk
// - Both read enables low load output register
// - Either read enable high holds output
// - Empty drives flag low, reads ignored
// - Write on empty buffer releases empty flag
// - Output enable low drives bus, else released
// - Mode strap sampled while reset low
// - Two-enable mode needs enable two high
// - Almost-full low at capacity minus offset
// - Almost-empty low near empty by offset
module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int DEPTH = DEPTH_DEFAULT
)(
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic reset_n, // FIFO reset pin, active low
  input wire logic [DATA_W-1:0] write_data_bus, // Write data pins
  input wire logic write_enable_one_n, // Write enable one, active low
  input wire logic write_enable_two_or_load, // Second write enable / mode strap
  input wire logic read_enable_one_n, // Read enable one, active low
  input wire logic read_enable_two_n, // Read enable two, active low
  input wire logic output_enable_n, // Output enable, active low
  output logic [DATA_W-1:0] read_data_bus, // Read data pins
  output logic read_data_oe, // High while read_data_bus is driven
  output logic full_flag_n, // Full, active low
  output logic almost_full_flag_n, // Almost full, active low
  output logic empty_flag_n, // Empty, active low
  output logic almost_empty_flag_n, // Almost empty, active low
  input wire logic [AXI_AW-1:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Write protection, unused
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [AXI_AW-1:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Read protection, unused
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam int PIN_W = DATA_W + 6;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [AW-1:0] OFS_RST = AW'(OFS_DEFAULT);

  // Pointer arithmetic relies on natural wrap, so the depth must be a power of two
  // and large enough to hold the default offsets
  if (DEPTH < 16 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 16");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;

  assign pin_raw = {reset_n, output_enable_n, read_enable_two_n, read_enable_one_n,
                    write_enable_two_or_load, write_enable_one_n, write_data_bus};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  logic [DATA_W-1:0] din_s;
  logic write_enable_one_n_n_s;
  logic wen2_s;
  logic read_enable_one_n_n_s;
  logic read_enable_two_n_n_s;
  logic oe_n_s;
  logic rst_n_s;

  assign din_s = pin_s2_r[DATA_W-1:0];
  assign write_enable_one_n_n_s = pin_s2_r[DATA_W];
  assign wen2_s = pin_s2_r[DATA_W+1];
  assign read_enable_one_n_n_s = pin_s2_r[DATA_W+2];
  assign read_enable_two_n_n_s = pin_s2_r[DATA_W+3];
  assign oe_n_s = pin_s2_r[DATA_W+4];
  assign rst_n_s = pin_s2_r[DATA_W+5];

  // Either the system reset or the FIFO reset pin clears the FIFO state
  logic fifo_rst;
  assign fifo_rst = !aresetn || !rst_n_s;

  // ----------------------------------------------------------------
  // Mode strap
  // ----------------------------------------------------------------
  logic two_wen_r;

  always_ff @(posedge aclk)
  begin
    if (fifo_rst)
      two_wen_r <= wen2_s;
  end

  // ----------------------------------------------------------------
  // Offset registers, written by software
  // ----------------------------------------------------------------
  logic [AW-1:0] empty_ofs_r;
  logic [AW-1:0] full_ofs_r;
  logic do_write;
  logic [AXI_AW-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  always_ff @(posedge aclk)
  begin
    if (fifo_rst)
    begin
      empty_ofs_r <= OFS_RST;
      full_ofs_r <= OFS_RST;
    end
    else if (do_write && w_strb_r[0])
    begin
      if (aw_addr_r == REG_EMPTY_OFS)
        empty_ofs_r <= w_data_r[AW-1:0];
      if (aw_addr_r == REG_FULL_OFS)
        full_ofs_r <= w_data_r[AW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Gray helpers
  // ----------------------------------------------------------------
  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    return b;
  endfunction

  // ----------------------------------------------------------------
  // Write side
  // ----------------------------------------------------------------
  logic [PW-1:0] wptr_r;
  logic [PW-1:0] wptr_nxt;
  logic [PW-1:0] wgray_r;
  logic [PW-1:0] rgray_r;
  logic [PW-1:0] rgray_s1_r;
  logic [PW-1:0] rgray_s2_r;
  logic [PW-1:0] rptr_at_w;
  logic [PW-1:0] wlevel_nxt;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] in_r;
  logic wr_en;
  logic full_n_r;
  logic afull_n_r;

  // A full FIFO ignores both enables
  assign wr_en = (two_wen_r ? (!write_enable_one_n_n_s && wen2_s) : !write_enable_one_n_n_s)
                 && full_n_r;
  assign wptr_nxt = wptr_r + PW'(wr_en);
  assign rptr_at_w = gray2bin(rgray_s2_r);
  assign wlevel_nxt = wptr_nxt - rptr_at_w;

  always_ff @(posedge aclk)
  begin
    if (fifo_rst)
    begin
      wptr_r <= '0;
      wgray_r <= '0;
    end
    else
    begin
      wptr_r <= wptr_nxt;
      wgray_r <= wptr_nxt ^ (wptr_nxt >> 1);
    end
  end

  // Enable high keeps the previous word in the input register
  always_ff @(posedge aclk)
  begin
    if (fifo_rst)
      in_r <= '0;
    else if (wr_en)
      in_r <= din_s;
  end

  always_ff @(posedge aclk)
  begin
    if (wr_en)
      mem[wptr_r[AW-1:0]] <= din_s;
  end

  // Read pointer seen from the write side
  always_ff @(posedge aclk)
  begin
    if (fifo_rst)
    begin
      rgray_s1_r <= '0;
      rgray_s2_r <= '0;
    end
    else
    begin
      rgray_s1_r <= rgray_r;
      rgray_s2_r <= rgray_s1_r;
    end
  end

  // The stale read pointer makes full pessimistic, never unsafe
  always_ff @(posedge aclk)
  begin
    if (fifo_rst)
    begin
      full_n_r <= FULL_N_RST;
      afull_n_r <= AFULL_N_RST;
    end
    else
    begin
      full_n_r <= (wlevel_nxt != DEPTH_P);
      afull_n_r <= (wlevel_nxt < DEPTH_P - {1'b0, full_ofs_r});
    end
  end

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  logic [PW-1:0] rptr_r;
  logic [PW-1:0] rptr_nxt;
  logic [PW-1:0] wgray_s1_r;
  logic [PW-1:0] wgray_s2_r;
  logic [PW-1:0] wptr_at_r;
  logic [PW-1:0] rlevel_nxt;
  logic [DATA_W-1:0] out_r;
  logic rd_en;
  logic empty_n_r;
  logic aempty_n_r;

  assign rd_en = !read_enable_one_n_n_s && !read_enable_two_n_n_s
                 && empty_n_r;
  assign rptr_nxt = rptr_r + PW'(rd_en);
  assign wptr_at_r = gray2bin(wgray_s2_r);
  assign rlevel_nxt = wptr_at_r - rptr_nxt;

  always_ff @(posedge aclk)
  begin
    if (fifo_rst)
    begin
      rptr_r <= '0;
      rgray_r <= '0;
    end
    else
    begin
      rptr_r <= rptr_nxt;
      rgray_r <= rptr_nxt ^ (rptr_nxt >> 1);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (fifo_rst)
      out_r <= '0;
    else if (rd_en)
      out_r <= mem[rptr_r[AW-1:0]];
  end

  // Write pointer seen from the read side
  always_ff @(posedge aclk)
  begin
    if (fifo_rst)
    begin
      wgray_s1_r <= '0;
      wgray_s2_r <= '0;
    end
    else
    begin
      wgray_s1_r <= wgray_r;
      wgray_s2_r <= wgray_s1_r;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (fifo_rst)
    begin
      empty_n_r <= EMPTY_N_RST;
      aempty_n_r <= AEMPTY_N_RST;
    end
    else
    begin
      empty_n_r <= (rlevel_nxt != '0);
      aempty_n_r <= (rlevel_nxt > {1'b0, empty_ofs_r});
    end
  end

  assign full_flag_n = full_n_r;
  assign almost_full_flag_n = afull_n_r;
  assign empty_flag_n = empty_n_r;
  assign almost_empty_flag_n = aempty_n_r;
  assign read_data_bus = out_r;
  assign read_data_oe = !oe_n_s;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic aw_held_r;
  logic w_held_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic aw_map;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign do_write = aw_held_r && w_held_r;
  assign aw_map = (aw_addr_r == REG_EMPTY_OFS) || (aw_addr_r == REG_FULL_OFS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
    else if (do_write)
      w_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= aw_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [31:0] rd_mux;
  logic rd_map;

  always_comb
  begin
    rd_mux = '0;
    rd_map = 1'b1;
    unique case (s_axi_araddr)
      REG_EMPTY_OFS: rd_mux[AW-1:0] = empty_ofs_r;
      REG_FULL_OFS: rd_mux[AW-1:0] = full_ofs_r;
      REG_STATUS:
      begin
        rd_mux[ST_FULL_N] = full_n_r;
        rd_mux[ST_AFULL_N] = afull_n_r;
        rd_mux[ST_AEMPTY_N] = aempty_n_r;
        rd_mux[ST_EMPTY_N] = empty_n_r;
        rd_mux[ST_TWO_WEN] = two_wen_r;
      end
      REG_LEVEL:
      begin
        rd_mux[PW-1:0] = wptr_r - rptr_at_w;
        rd_mux[LVL_RD_POS +: PW] = wptr_at_r - rptr_r;
      end
      REG_LAST_IN: rd_mux[DATA_W-1:0] = in_r;
      default: rd_map = 1'b0;
    endcase
  end

  assign s_axi_arready = !rvalid_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule

// ### hw/dcf_pkg.sv
// Shared constants for the dual-port 9-bit FIFO with register access
package dcf_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 9;
  localparam int DEPTH_DEFAULT = 64;
  localparam int OFS_DEFAULT = 7;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_EMPTY_OFS = 8'h00;
  localparam logic [AXI_AW-1:0] REG_FULL_OFS = 8'h04;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
  localparam logic [AXI_AW-1:0] REG_LEVEL = 8'h0c;
  localparam logic [AXI_AW-1:0] REG_LAST_IN = 8'h10;

  // ----------------------------------------------------------------
  // Status fields and level fields
  // ----------------------------------------------------------------
  localparam int ST_FULL_N = 0;
  localparam int ST_AFULL_N = 1;
  localparam int ST_AEMPTY_N = 2;
  localparam int ST_EMPTY_N = 3;
  localparam int ST_TWO_WEN = 4;
  localparam int LVL_RD_POS = 16;

  // ----------------------------------------------------------------
  // Flag values held during reset
  // ----------------------------------------------------------------
  localparam logic FULL_N_RST = 1'b1;
  localparam logic AFULL_N_RST = 1'b1;
  localparam logic EMPTY_N_RST = 1'b0;
  localparam logic AEMPTY_N_RST = 1'b0;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### verif/dcf_fifo_properties.sv
// Pin-side concurrent checks for the dual-port FIFO
module dcf_fifo_chk
  import dcf_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic reset_n, // FIFO reset pin
  input wire logic write_enable_one_n, // Write enable one
  input wire logic read_enable_one_n, // Read enable one
  input wire logic output_enable_n, // Output enable
  input wire logic [DATA_W-1:0] read_data_bus, // Read data
  input wire logic read_data_oe, // Bus driven
  input wire logic full_flag_n, // Full
  input wire logic almost_full_flag_n, // Almost full
  input wire logic empty_flag_n, // Empty
  input wire logic almost_empty_flag_n // Almost empty
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Pin reset passes two sync stages before it lands
  property p_rst_flags;
    !reset_n[*3] |=> full_flag_n && almost_full_flag_n && !empty_flag_n && !almost_empty_flag_n;
  endproperty
  a_rst_flags: assert property (p_rst_flags) else $error("flags not at reset values");
  property p_rst_out;
    !reset_n[*3] |=> read_data_bus == '0;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("output register not cleared");
  property p_out_hold;
    (read_enable_one_n && reset_n)[*3] |=> $stable(read_data_bus);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output changed without read");
  // Eight quiet cycles cover the sync lag of a late request
  property p_full_hold;
    (read_enable_one_n && reset_n)[*8] ##0 !full_flag_n |=> !full_flag_n;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("full released without read");
  property p_empty_hold;
    (write_enable_one_n && reset_n)[*8] ##0 !empty_flag_n |=> !empty_flag_n;
  endproperty
  a_empty_hold: assert property (p_empty_hold) else $error("empty released without write");
  property p_full_afull;
    !full_flag_n |-> !almost_full_flag_n;
  endproperty
  a_full_afull: assert property (p_full_afull) else $error("full without almost full");
  property p_empty_aempty;
    !empty_flag_n |-> !almost_empty_flag_n;
  endproperty
  a_empty_aempty: assert property (p_empty_aempty) else $error("empty without almost empty");
  property p_oe_off;
    output_enable_n[*4] |-> !read_data_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven while disabled");
  property p_oe_on;
    !output_enable_n[*4] |-> read_data_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus released while enabled");
endmodule

bind dcf_fifo dcf_fifo_chk chk_u (.*);

// ### verif/dcf_agent.sv
// Pin agent standing in for the writing and reading controllers
module dcf_agent
  import dcf_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic wr_go, // Write one word now
  input wire logic [DATA_W-1:0] wr_word, // Word to write
  input wire logic rd_one, // Pull read enable one low
  input wire logic rd_two, // Pull read enable two low
  output logic write_enable_one_n = 1'b1, // To FIFO
  output logic [DATA_W-1:0] write_data_bus = '0, // To FIFO
  output logic read_enable_one_n = 1'b1, // To FIFO
  output logic read_enable_two_n = 1'b1 // To FIFO
);
  logic seen_rst_r = 1'b0;

  // Idle data toggles so a stale word is never mistaken for a write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      seen_rst_r <= 1'b1;
    write_enable_one_n <= !(wr_go && seen_rst_r);
    write_data_bus <= wr_go ? wr_word : ~write_data_bus;
    read_enable_one_n <= !rd_one;
    read_enable_two_n <= !rd_two;
  end
endmodule

// ### verif/dcf_fifo_tb.sv
// Self-checking bench for the dual-port FIFO
module dcf_fifo_tb
  import dcf_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 16;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic reset_n = 1'b1;
  logic wr_go = 1'b0;
  logic rd_one = 1'b0;
  logic rd_two = 1'b0;
  logic [DATA_W-1:0] wr_word = '0;
  logic write_enable_two_or_load = 1'b0;
  logic output_enable_n = 1'b0;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic write_enable_one_n, read_enable_one_n, read_enable_two_n;
  logic [DATA_W-1:0] write_data_bus, read_data_bus;
  logic read_data_oe, full_flag_n, almost_full_flag_n, empty_flag_n, almost_empty_flag_n;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_val;
  int fails = 0;
  int checked = 0;
  int eofs = OFS_DEFAULT;
  int fofs = OFS_DEFAULT;
  logic [DATA_W-1:0] q[$];
  logic [DATA_W-1:0] last_out = '0;

  dcf_fifo #(.DEPTH(DEPTH)) dut_u (.*);
  dcf_agent agent_u (.*);

  initial
  begin
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic guard(input bit got);
    if (!got)
    begin
      chk("bus wait", 32'h0, 32'h1);
      test_done();
    end
  endtask

  // Flags as {full, almost full, almost empty, empty}, all active low
  function automatic logic [3:0] exp_flags(input int c);
    return {c != DEPTH, c < DEPTH - fofs, c > eofs, c != 0};
  endfunction

  task automatic chk_flags(input string what);
    chk(what, 32'({full_flag_n, almost_full_flag_n, almost_empty_flag_n, empty_flag_n}),
        32'(exp_flags(q.size())));
    $display("%s done", what);
  endtask

  task automatic settle();
    repeat (8) @(posedge aclk);
  endtask

  task automatic wr_words(input int n, input bit store);
    logic [DATA_W-1:0] w;
    repeat (n)
    begin
      w = DATA_W'($urandom);
      wr_go <= 1'b1;
      wr_word <= w;
      if (store && q.size() < DEPTH)
        q.push_back(w);
      @(posedge aclk);
    end
    wr_go <= 1'b0;
    settle();
  endtask

  task automatic rd_word(input bit both);
    rd_one <= 1'b1;
    rd_two <= both;
    @(posedge aclk);
    rd_one <= 1'b0;
    rd_two <= 1'b0;
    settle();
    if (both && q.size() > 0)
      last_out = q.pop_front();
    chk("read word", 32'(read_data_bus), 32'(last_out));
  endtask

  task automatic axi_wr(input logic [AXI_AW-1:0] a, input int d, input logic [1:0] er);
    bit got;
    got = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= 32'(d);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50 && !got; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      got = s_axi_bvalid;
    end
    // Ready stays up between calls so no signal is driven twice in one step
    guard(got);
    chk("write response", 32'(s_axi_bresp), 32'(er));
  endtask

  task automatic axi_rd(input logic [AXI_AW-1:0] a, input logic [1:0] er);
    bit got;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50 && !got; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      got = s_axi_rvalid;
      rd_val = s_axi_rdata;
    end
    guard(got);
    chk("read response", 32'(s_axi_rresp), 32'(er));
  endtask

  initial
  begin
    void'($urandom(32'h2998));
    repeat (2) @(posedge aclk);
    chk_flags("reset flags");
    chk("reset output", 32'(read_data_bus), 32'h0);
    aresetn <= 1'b1;
    settle();
    axi_rd(REG_EMPTY_OFS, RESP_OKAY);
    chk("empty offset", rd_val, 32'(OFS_DEFAULT));
    axi_rd(REG_FULL_OFS, RESP_OKAY);
    chk("full offset", rd_val, 32'(OFS_DEFAULT));
    axi_rd(8'h40, RESP_SLVERR);
    axi_wr(REG_LEVEL, 0, RESP_SLVERR);
    eofs = $urandom_range(5, 1);
    fofs = $urandom_range(5, 1);
    axi_wr(REG_EMPTY_OFS, eofs, RESP_OKAY);
    axi_wr(REG_FULL_OFS, fofs, RESP_OKAY);
    wr_words(1, 1'b1);
    axi_rd(REG_LAST_IN, RESP_OKAY);
    chk("last input", rd_val, 32'(q[0]));
    while (q.size() < DEPTH)
    begin
      wr_words($urandom_range(4, 1), 1'b1);
      chk_flags("fill flags");
    end
    wr_words(2, 1'b1);
    chk_flags("overflow flags");
    output_enable_n <= 1'b1;
    rd_word(1'b0);
    repeat (DEPTH + 1)
    begin
      rd_word(1'b1);
      chk_flags("drain flags");
    end
    chk("bus off", 32'(read_data_oe), 32'h0);
    output_enable_n <= 1'b0;
    settle();
    chk("bus on", 32'(read_data_oe), 32'h1);
    write_enable_two_or_load <= 1'b1;
    reset_n <= 1'b0;
    wr_words(2, 1'b0);
    reset_n <= 1'b1;
    settle();
    q.delete();
    last_out = '0;
    eofs = OFS_DEFAULT;
    fofs = OFS_DEFAULT;
    chk_flags("pin reset flags");
    axi_rd(REG_STATUS, RESP_OKAY);
    chk("two enable mode", 32'(rd_val[ST_TWO_WEN]), 32'h1);
    chk("status flags", 32'(rd_val[3:0]),
        32'({EMPTY_N_RST, AEMPTY_N_RST, AFULL_N_RST, FULL_N_RST}));
    write_enable_two_or_load <= 1'b0;
    wr_words(3, 1'b0);
    chk_flags("gated writes");
    write_enable_two_or_load <= 1'b1;
    wr_words(3, 1'b1);
    chk_flags("two enable writes");
    axi_rd(REG_LEVEL, RESP_OKAY);
    chk("fill level", rd_val, 32'(3) | (32'(3) << LVL_RD_POS));
    rd_word(1'b1);
    test_done();
  end
endmodule
